// File: core/host_port_pkg.sv
// Constants and state types shared by the host parallel access port and its write buffer.
// Assumes one core clock domain; every host pin is asynchronous to it.
package host_port_pkg;

	localparam int          WORD_W      = 32;
	localparam int          HALF_W      = 16;
	localparam int          WBUF_DEPTH  = 16;
	localparam int          WBUF_W      = 2 * WORD_W;

	// Memory-mapped register offsets as seen by the on-chip CPU.
	localparam logic [31:0] OFF_CTRL    = 32'h0188_0000;
	localparam logic [31:0] OFF_AW      = 32'h0188_0004;
	localparam logic [31:0] OFF_AR      = 32'h0188_0008;
	localparam logic [31:0] OFF_TRCTL   = 32'h018a_0000;

	localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
	localparam logic [31:0] ADDR_STEP   = 32'h0000_0004;
	localparam logic [15:0] HALF_ZERO   = 16'h0000;

	// Writable bits of port_control and the read-only status bits beside them.
	localparam logic [31:0] CTRL_RW_MASK   = 32'h0000_00ff;
	localparam logic [31:0] CTRL_ORDER_BIT = 32'h0000_0001;
	localparam logic [31:0] CTRL_BUSY_BIT  = 32'h0000_0100;
	localparam logic [31:0] CTRL_FULL_BIT  = 32'h0000_0200;

	// Access-select codes.
	localparam logic [1:0]  SEL_CTRL     = 2'h0;
	localparam logic [1:0]  SEL_DATA_INC = 2'h1;
	localparam logic [1:0]  SEL_ADDR     = 2'h2;
	localparam logic [1:0]  SEL_DATA_FIX = 2'h3;

	// Pin function of the shared pins.
	localparam logic [1:0]  FUNC_PCI    = 2'h0;
	localparam logic [1:0]  FUNC_HOST32 = 2'h1;
	localparam logic [1:0]  FUNC_HOST16 = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_FETCH = 4'b0010,
		ST_WBUF  = 4'b0100,
		ST_DONE  = 4'b1000
	} host_state_e;

	typedef struct packed {
		logic [1:0] acc;
		logic       rnw;
		logic       hws;
	} sel_s;

	typedef struct packed {
		logic       cs_n;
		logic       ds1;
		logic       ds2;
		logic       as_n;
		sel_s       sel;
		logic [1:0] func;
	} pins_s;

	typedef struct packed {
		pins_s              pin_s1;
		pins_s              pin_s2;
		logic [WORD_W-1:0]  dat_s1;
		logic [WORD_W-1:0]  dat_s2;
		logic               stb_q;
		logic               as_q;
		logic               as_seen;
		sel_s               sel_l;
		sel_s               sel_q;
		host_state_e        st;
		logic [WORD_W-1:0]  ctrl;
		logic [WORD_W-1:0]  aw;
		logic [WORD_W-1:0]  ar;
		logic [WORD_W-1:0]  trctl;
		logic [WORD_W-1:0]  win;
		logic [HALF_W-1:0]  half_buf;
		logic               rdy_n;
		logic               oe;
		logic [WORD_W-1:0]  dout;
		logic               push;
		logic [WBUF_W-1:0]  push_data;
		logic               mem_req;
		logic               mem_we;
		logic [WORD_W-1:0]  mem_addr;
		logic [WORD_W-1:0]  mem_wdata;
		logic [WORD_W-1:0]  cpu_rdata;
		logic               cpu_ack;
	} port_state_s;

endpackage : host_port_pkg

// File: core/wbuf_if.sv
// Carrier between the port logic and its write buffer.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
`default_nettype none
interface wbuf_if #(parameter int WIDTH = 64);
	logic             wr_valid;
	logic             wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic             rd_valid;
	logic             rd_ready;
	logic [WIDTH-1:0] rd_data;

	modport fifo (input wr_valid, input wr_data, input rd_ready,
		output wr_ready, output rd_valid, output rd_data);
	modport user (output wr_valid, output wr_data, output rd_ready,
		input wr_ready, input rd_valid, input rd_data);
endinterface : wbuf_if
`default_nettype wire

// File: core/write_fifo.sv
// Write buffer between host data-window writes and the internal memory engine.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/10ps
`default_nettype none
module write_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 16
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	wbuf_if.fifo      port
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wp;
		logic [AW:0]                 rp;
	} fifo_s;

	fifo_s s_reg;
	fifo_s s_next;
	logic  full;
	logic  empty;

	assign empty = (s_reg.wp == s_reg.rp);
	assign full  = (s_reg.wp[AW] != s_reg.rp[AW]) && (s_reg.wp[AW-1:0] == s_reg.rp[AW-1:0]);
	assign port.wr_ready = !full;
	assign port.rd_valid = !empty;
	assign port.rd_data  = s_reg.mem[s_reg.rp[AW-1:0]];

	always_comb begin
		s_next = s_reg;
		if (port.wr_valid && !full) begin
			s_next.mem[s_reg.wp[AW-1:0]] = port.wr_data;
			s_next.wp = s_reg.wp + 1'b1;
		end
		if (port.rd_ready && !empty) begin
			s_next.rp = s_reg.rp + 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule : write_fifo
`default_nettype wire

// File: core/host_parallel_access_port.sv
// Parallel host access port: host pins, CPU register port and internal memory request port.
// Assumes host pins are asynchronous and the memory engine answers on the core clock.
//
// Operation
// RQ1: Combined strobe is chip select OR data-strobe XNOR.
// RQ2: Host address write loads both pointer copies.
// RQ3: CPU accesses each pointer copy on its own.
// RQ4: Data window has no CPU address.
// RQ5: Host and CPU both reach port control.
// RQ6: Host holds strobe until ready goes low.
// RQ7: Window read fetches at strobe fall, ready high.
// RQ8: Ready stays high while write buffer is full.
// RQ9: Host pulses address strobe once per strobe.
// RQ10: Select lines latched once per access.
// RQ11: Second half-word read needs no new fetch.
// RQ12: Data bus driven only during reads.
// RQ13: Shared pins: PCI, 32-bit or 16-bit port.
// RQ14: Host masters transfers; device only responds.
// RQ15: Reserved addresses read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none
module host_parallel_access_port
	import host_port_pkg::*;
(
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_chip_select_n,
	input  wire logic              i_data_strobe_one,
	input  wire logic              i_data_strobe_two,
	input  wire logic              i_address_strobe_n,
	input  wire logic [1:0]        i_access_select,
	input  wire logic              i_read_not_write,
	input  wire logic              i_halfword_select,
	input  wire logic [1:0]        i_pin_function,
	input  wire logic [WORD_W-1:0] i_host_data_bus,
	output var  logic [WORD_W-1:0] o_host_data_bus,
	output var  logic              o_host_data_bus_oe,
	output var  logic              o_ready_n,
	input  wire logic              i_cpu_req,
	input  wire logic              i_cpu_we,
	input  wire logic [WORD_W-1:0] i_cpu_addr,
	input  wire logic [WORD_W-1:0] i_cpu_wdata,
	output var  logic [WORD_W-1:0] o_cpu_rdata,
	output var  logic              o_cpu_ack,
	output var  logic              o_mem_req,
	output var  logic              o_mem_we,
	output var  logic [WORD_W-1:0] o_mem_addr,
	output var  logic [WORD_W-1:0] o_mem_wdata,
	input  wire logic              i_mem_ack,
	input  wire logic [WORD_W-1:0] i_mem_rdata
);
	port_state_s       s_reg;
	port_state_s       s_next;
	logic              stb;
	logic              fall;
	logic              rise;
	logic              as_fall;
	logic              half16;
	logic              pop;
	sel_s              sel_now;
	logic [WORD_W-1:0] ctrl_view;

	wbuf_if #(.WIDTH(WBUF_W)) wb ();

	write_fifo #(.WIDTH(WBUF_W), .DEPTH(WBUF_DEPTH)) u_wbuf (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.port       (wb.fifo)
	);

	assign wb.wr_valid = s_reg.push;
	assign wb.wr_data  = s_reg.push_data;
	assign wb.rd_ready = pop;

	// The strobe is never asserted while the pins serve the PCI bus.
	assign stb     = s_reg.pin_s2.cs_n | ~(s_reg.pin_s2.ds1 ^ s_reg.pin_s2.ds2) // RQ1
		| (s_reg.pin_s2.func == FUNC_PCI); // RQ13
	assign fall    = s_reg.stb_q & ~stb;
	assign rise    = ~s_reg.stb_q & stb;
	assign as_fall = s_reg.as_q & ~s_reg.pin_s2.as_n;
	assign half16  = (s_reg.pin_s2.func == FUNC_HOST16); // RQ13
	assign sel_now = s_reg.as_seen ? s_reg.sel_l : s_reg.pin_s2.sel; // RQ10
	assign ctrl_view = s_reg.ctrl
		| ((s_reg.st == ST_FETCH) ? CTRL_BUSY_BIT : RESET_WORD)
		| (wb.wr_ready ? RESET_WORD : CTRL_FULL_BIT);

	// In 16-bit mode the order bit of port_control says which half moves first.
	function automatic logic [WORD_W-1:0] pick(input logic [WORD_W-1:0] v, input logic second,
		input logic wide16, input logic order);
		logic take_hi;
		take_hi = second ^ order;
		if (!wide16) begin
			pick = v;
		end else begin
			pick = {HALF_ZERO, take_hi ? v[WORD_W-1:HALF_W] : v[HALF_W-1:0]};
		end
	endfunction : pick

	function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old,
		input logic [WORD_W-1:0] v, input logic second, input logic wide16, input logic order);
		logic take_hi;
		take_hi = second ^ order;
		if (!wide16) begin
			merge = v;
		end else if (take_hi) begin
			merge = {v[HALF_W-1:0], old[HALF_W-1:0]};
		end else begin
			merge = {old[WORD_W-1:HALF_W], v[HALF_W-1:0]};
		end
	endfunction : merge

	always_comb begin
		logic              order;
		logic              is_data;
		logic [WORD_W-1:0] v;
		s_next  = s_reg;
		pop     = 1'b0;
		order   = |(s_reg.ctrl & CTRL_ORDER_BIT);
		is_data = (s_reg.sel_q.acc == SEL_DATA_INC) || (s_reg.sel_q.acc == SEL_DATA_FIX);
		v       = RESET_WORD;
		s_next.pin_s1 = {i_chip_select_n, i_data_strobe_one, i_data_strobe_two,
			i_address_strobe_n, i_access_select, i_read_not_write, i_halfword_select,
			i_pin_function};
		s_next.pin_s2 = s_reg.pin_s1;
		s_next.dat_s1 = i_host_data_bus;
		s_next.dat_s2 = s_reg.dat_s1;
		s_next.stb_q  = stb;
		s_next.as_q   = s_reg.pin_s2.as_n;
		s_next.push   = 1'b0;
		s_next.cpu_ack = 1'b0;

		// Selects are caught at the address strobe when the host uses it.
		if (as_fall && stb) begin
			s_next.as_seen = 1'b1; // RQ9
			s_next.sel_l   = s_reg.pin_s2.sel; // RQ10
		end

		// The data window has no decode here, so the CPU can never reach it.
		if (i_cpu_req) begin
			s_next.cpu_ack = 1'b1;
			unique case (i_cpu_addr)
				OFF_CTRL:  s_next.cpu_rdata = ctrl_view; // RQ5
				OFF_AW:    s_next.cpu_rdata = s_reg.aw; // RQ3
				OFF_AR:    s_next.cpu_rdata = s_reg.ar; // RQ3
				OFF_TRCTL: s_next.cpu_rdata = s_reg.trctl;
				default:   s_next.cpu_rdata = RESET_WORD; // RQ4 RQ15
			endcase
			if (i_cpu_we) begin
				unique case (i_cpu_addr)
					OFF_CTRL:  s_next.ctrl  = i_cpu_wdata & CTRL_RW_MASK; // RQ5
					OFF_AW:    s_next.aw    = i_cpu_wdata; // RQ3
					OFF_AR:    s_next.ar    = i_cpu_wdata; // RQ3
					OFF_TRCTL: s_next.trctl = i_cpu_wdata;
					default:   s_next.trctl = s_reg.trctl; // RQ15
				endcase
			end
		end

		if (s_reg.mem_req && i_mem_ack) begin
			s_next.mem_req = 1'b0;
		end

		// Buffered writes drain first so that a later read sees them in memory.
		if (!s_reg.mem_req && wb.rd_valid) begin
			pop              = 1'b1;
			s_next.mem_req   = 1'b1;
			s_next.mem_we    = 1'b1;
			s_next.mem_addr  = wb.rd_data[WBUF_W-1:WORD_W];
			s_next.mem_wdata = wb.rd_data[WORD_W-1:0];
		end

		// Host accesses below come after the CPU so a host write wins a collision.
		unique case (s_reg.st)
			ST_IDLE: begin
				if (fall) begin // RQ14
					s_next.sel_q = sel_now; // RQ10
					s_next.oe    = sel_now.rnw; // RQ12
					if ((sel_now.acc == SEL_DATA_INC) || (sel_now.acc == SEL_DATA_FIX)) begin
						if (sel_now.rnw && half16 && sel_now.hws) begin
							s_next.dout  = pick(s_reg.win, 1'b1, half16, order); // RQ11
							s_next.rdy_n = 1'b0;
							s_next.st    = ST_DONE;
						end else if (sel_now.rnw) begin
							s_next.st = ST_FETCH; // RQ7
						end else if (wb.wr_ready) begin
							s_next.rdy_n = 1'b0;
							s_next.st    = ST_DONE;
						end else begin
							s_next.st = ST_WBUF; // RQ8
						end
					end else begin
						if (sel_now.acc == SEL_CTRL) begin
							v = ctrl_view;
						end else begin
							v = s_reg.ar;
						end
						s_next.dout  = pick(v, sel_now.hws, half16, order);
						s_next.rdy_n = 1'b0;
						s_next.st    = ST_DONE;
					end
				end
			end
			ST_FETCH: begin
				if (rise) begin
					// An early release abandons the access; a fetch in flight just completes.
					s_next.oe      = 1'b0; // RQ6
					s_next.as_seen = 1'b0;
					s_next.st      = ST_IDLE;
				end else if (s_reg.mem_req && !s_reg.mem_we && i_mem_ack) begin
					s_next.win   = i_mem_rdata;
					s_next.dout  = pick(i_mem_rdata, 1'b0, half16, order); // RQ7
					s_next.rdy_n = 1'b0;
					s_next.st    = ST_DONE;
					if (!half16 && (s_reg.sel_q.acc == SEL_DATA_INC)) begin
						s_next.ar = s_reg.ar + ADDR_STEP;
					end
				end else if (!s_reg.mem_req && !wb.rd_valid) begin
					s_next.mem_req  = 1'b1; // RQ7
					s_next.mem_we   = 1'b0;
					s_next.mem_addr = s_reg.ar;
				end
			end
			ST_WBUF: begin
				if (rise) begin
					s_next.as_seen = 1'b0; // RQ6
					s_next.st      = ST_IDLE;
				end else if (wb.wr_ready) begin
					s_next.rdy_n = 1'b0; // RQ8
					s_next.st    = ST_DONE;
				end
			end
			ST_DONE: begin
				if (rise) begin
					s_next.rdy_n   = 1'b1;
					s_next.oe      = 1'b0; // RQ12
					s_next.as_seen = 1'b0;
					s_next.st      = ST_IDLE;
					if (s_reg.sel_q.rnw) begin
						if (half16 && s_reg.sel_q.hws && (s_reg.sel_q.acc == SEL_DATA_INC)) begin
							s_next.ar = s_reg.ar + ADDR_STEP;
						end
					end else if (s_reg.sel_q.acc == SEL_CTRL) begin
						s_next.ctrl = merge(s_reg.ctrl, s_reg.dat_s2, s_reg.sel_q.hws, half16,
							order) & CTRL_RW_MASK; // RQ5
					end else if (s_reg.sel_q.acc == SEL_ADDR) begin
						v = merge(s_reg.aw, s_reg.dat_s2, s_reg.sel_q.hws, half16, order);
						s_next.aw = v; // RQ2
						s_next.ar = v; // RQ2
					end else if (is_data && half16 && !s_reg.sel_q.hws) begin
						s_next.half_buf = s_reg.dat_s2[HALF_W-1:0];
					end else begin
						v = merge({s_reg.half_buf, s_reg.half_buf}, s_reg.dat_s2, 1'b1, half16,
							order);
						s_next.push      = 1'b1;
						s_next.push_data = {s_reg.aw, v};
						if (s_reg.sel_q.acc == SEL_DATA_INC) begin
							s_next.aw = s_reg.aw + ADDR_STEP;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_reg         <= '0;
			s_reg.pin_s1  <= '1;
			s_reg.pin_s2  <= '1;
			s_reg.stb_q   <= 1'b1;
			s_reg.as_q    <= 1'b1;
			s_reg.rdy_n   <= 1'b1;
			s_reg.st      <= ST_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_host_data_bus    = s_reg.dout;
	assign o_host_data_bus_oe = s_reg.oe;
	assign o_ready_n          = s_reg.rdy_n;
	assign o_cpu_rdata        = s_reg.cpu_rdata;
	assign o_cpu_ack          = s_reg.cpu_ack;
	assign o_mem_req          = s_reg.mem_req;
	assign o_mem_we           = s_reg.mem_we;
	assign o_mem_addr         = s_reg.mem_addr;
	assign o_mem_wdata        = s_reg.mem_wdata;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	sequence host_addr_write_s;
		(s_reg.st == ST_DONE) && rise && !s_reg.sel_q.rnw && (s_reg.sel_q.acc == SEL_ADDR);
	endsequence

	sequence second_half_fall_s;
		(s_reg.st == ST_IDLE) && fall && half16 && sel_now.rnw && sel_now.hws
			&& ((sel_now.acc == SEL_DATA_INC) || (sel_now.acc == SEL_DATA_FIX));
	endsequence

	strobe_gate_a: assert property (s_reg.pin_s2.cs_n |-> !fall) // RQ1
		else $error("Strobe fell while chip select was inactive.");
	addr_copies_a: assert property (host_addr_write_s |=> (s_reg.aw == s_reg.ar)) // RQ2
		else $error("Host address write left the pointer copies different.");
	cpu_split_a: assert property (i_cpu_req && i_cpu_we && (i_cpu_addr == OFF_AW)
		&& (s_reg.st == ST_IDLE) |=> $stable(s_reg.ar)) // RQ3
		else $error("CPU write of the write copy changed the read copy.");
	window_hidden_a: assert property (i_cpu_req && i_cpu_we && (s_reg.st != ST_FETCH)
		|=> $stable(s_reg.win)) // RQ4
		else $error("CPU write reached the data window.");
	ctrl_cpu_a: assert property (i_cpu_req && i_cpu_we && (i_cpu_addr == OFF_CTRL)
		&& !((s_reg.st == ST_DONE) && rise)
		|=> s_reg.ctrl == ($past(i_cpu_wdata) & CTRL_RW_MASK)) // RQ5
		else $error("CPU write of port control was lost.");
	fetch_wait_a: assert property ((s_reg.st == ST_FETCH) |-> s_reg.rdy_n) // RQ7
		else $error("Ready went low before the fetched word arrived.");
	fetch_issue_a: assert property ((s_reg.st == ST_FETCH) && !s_reg.mem_req && !wb.rd_valid
		&& !rise |=> s_reg.mem_req && !s_reg.mem_we && (s_reg.mem_addr == $past(s_reg.ar))) // RQ7
		else $error("Window read did not request the read-copy address.");
	buf_full_a: assert property ($rose(s_reg.st == ST_WBUF) |-> $past(!wb.wr_ready)
		##0 s_reg.rdy_n) // RQ8
		else $error("Write stall entered with buffer space free.");
	select_hold_a: assert property ((s_reg.st != ST_IDLE) && $past(s_reg.st != ST_IDLE)
		|-> $stable(s_reg.sel_q)) // RQ10
		else $error("Latched selects changed inside an access.");
	second_half_a: assert property (second_half_fall_s |=> !s_reg.rdy_n
		&& (s_reg.st == ST_DONE) ##1 (s_reg.st != ST_FETCH)) // RQ11
		else $error("Second half-word read did not answer from the held word.");
	bus_release_a: assert property (s_reg.oe && rise |=> !s_reg.oe) // RQ12
		else $error("Data bus still driven after the strobe rose.");
	read_only_a: assert property (s_reg.oe |-> s_reg.sel_q.rnw) // RQ12
		else $error("Data bus driven during a write.");
	pci_quiet_a: assert property ((s_reg.pin_s2.func == FUNC_PCI) && (s_reg.st == ST_IDLE)
		|=> !s_reg.oe && s_reg.rdy_n) // RQ13
		else $error("Host port answered while pins serve PCI.");
	respond_only_a: assert property ($fell(s_reg.rdy_n) |-> !$past(stb)) // RQ14
		else $error("Ready asserted without a host strobe.");
	reserved_zero_a: assert property (i_cpu_req && !i_cpu_we && (i_cpu_addr != OFF_CTRL)
		&& (i_cpu_addr != OFF_AW) && (i_cpu_addr != OFF_AR) && (i_cpu_addr != OFF_TRCTL)
		|=> o_cpu_ack && (o_cpu_rdata == RESET_WORD)) // RQ15
		else $error("Reserved address did not read zero.");
endmodule : host_parallel_access_port
`default_nettype wire

// File: verification/mem_engine_model.sv
// Behavioural model of the internal memory engine behind the port's memory request port.
// Assumes the port holds request, address and data until the one-cycle acknowledge.
`timescale 1ns/10ps
`default_nettype none
module mem_engine_model
	import host_port_pkg::*;
(
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_stall,
	input  wire logic              i_mem_req,
	input  wire logic              i_mem_we,
	input  wire logic [WORD_W-1:0] i_mem_addr,
	input  wire logic [WORD_W-1:0] i_mem_wdata,
	output var  logic              o_mem_ack,
	output var  logic [WORD_W-1:0] o_mem_rdata
);
	logic [WORD_W-1:0] mem_reg [64];
	logic              take;

	assign take = i_mem_req && !o_mem_ack && !i_stall;

	initial begin
		for (int i = 0; i < 64; i++) begin
			mem_reg[i] = {8'h5a, 8'(i), 8'hc3, 8'(i)};
		end
	end

	// Read data flips every idle cycle, so a capture at the wrong edge cannot match.
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mem_ack   <= 1'b0;
			o_mem_rdata <= 32'h0000_0000;
		end else begin
			o_mem_ack   <= take;
			o_mem_rdata <= (take && !i_mem_we) ? mem_reg[i_mem_addr[7:2]] : ~o_mem_rdata;
			if (take && i_mem_we) begin
				mem_reg[i_mem_addr[7:2]] <= i_mem_wdata;
			end
		end
	end
endmodule : mem_engine_model
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench: host pin accesses and CPU register accesses against the port.
// Assumes the memory engine model answers the port's memory requests.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import host_port_pkg::*;
	localparam int DRV     = 1;
	localparam int TIMEOUT = 20000;
	// Decoded CPU offsets, index 0 first: control, write copy, read copy, transfer control.
	localparam logic [3:0][31:0] REG_OFFS = {OFF_TRCTL, OFF_AR, OFF_AW, OFF_CTRL};
	logic              i_core_clk, i_rst_n, cs_n, ds1, ds2, as_n, rnw, hws, pol;
	logic              cpu_req, cpu_we, stall, cpu_ack, oe, ready_n, mem_req, mem_we, mem_ack;
	logic              got, oe_at;
	logic [1:0]        acc, func;
	logic [WORD_W-1:0] hd_in, hd_out, cpu_addr, cpu_wdata, cpu_rdata, rd;
	logic [WORD_W-1:0] mem_addr, mem_wdata, mem_rdata;
	int                err_count, samples_checked, cycles, fetches, n, f0;

	host_parallel_access_port dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_chip_select_n(cs_n), .i_data_strobe_one(ds1), .i_data_strobe_two(ds2),
		.i_address_strobe_n(as_n), .i_access_select(acc), .i_read_not_write(rnw),
		.i_halfword_select(hws), .i_pin_function(func), .i_host_data_bus(hd_in),
		.o_host_data_bus(hd_out), .o_host_data_bus_oe(oe), .o_ready_n(ready_n),
		.i_cpu_req(cpu_req), .i_cpu_we(cpu_we), .i_cpu_addr(cpu_addr),
		.i_cpu_wdata(cpu_wdata), .o_cpu_rdata(cpu_rdata), .o_cpu_ack(cpu_ack),
		.o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr),
		.o_mem_wdata(mem_wdata), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata));
	mem_engine_model eng (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_stall(stall),
		.i_mem_req(mem_req), .i_mem_we(mem_we), .i_mem_addr(mem_addr),
		.i_mem_wdata(mem_wdata), .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata));

	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end

	function automatic logic [31:0] pat(input int i);
		return {8'h5a, 8'(i), 8'hc3, 8'(i)};
	endfunction : pat

	task automatic complete_run();
		if (err_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
			err_count++;
		end
	endtask : check

	always @(posedge i_core_clk) begin
		cycles++;
		if (mem_ack === 1'b1 && mem_req === 1'b1 && mem_we === 1'b0) begin
			fetches++;
		end
		if (cycles == TIMEOUT) begin
			err_count++;
			complete_run();
		end
	end

	task automatic cpu_rw(input logic we, input logic [31:0] a, input logic [31:0] wd);
		cpu_req   = 1'b1;
		cpu_we    = we;
		cpu_addr  = a;
		cpu_wdata = wd;
		@(posedge i_core_clk);
		#DRV;
		cpu_req = 1'b0;
		check("cpu ack", 32'h1, {31'h0, cpu_ack});
		rd = cpu_rdata;
		@(posedge i_core_clk);
		#DRV;
	endtask : cpu_rw

	// The strobe pins alternate polarity so data strobe one starts accesses on both of its edges.
	task automatic host_go(input logic [1:0] a, input logic r, input logic h, input logic [31:0] d);
		acc   = a;
		rnw   = r;
		hws   = h;
		hd_in = d;
		@(posedge i_core_clk);
		#DRV;
		cs_n = 1'b0;
		ds1  = pol;
		ds2  = !pol;
		pol  = !pol;
	endtask : host_go

	task automatic host_wait(input int lim);
		got = 1'b0;
		for (int i = 0; i < lim && !got; i++) begin
			@(posedge i_core_clk);
			got = (ready_n === 1'b0);
		end
	endtask : host_wait

	// Strobe is held until ready is seen low; data and enable are taken at that edge.
	task automatic host_end();
		rd    = hd_out;
		oe_at = oe;
		#DRV;
		cs_n = 1'b1;
		ds2  = ds1;
		repeat (5) @(posedge i_core_clk);
		check("bus released", 32'h0, {31'h0, oe});
		check("ready idle", 32'h1, {31'h0, ready_n});
		#DRV;
	endtask : host_end

	task automatic host_x(input logic [1:0] a, input logic r, input logic h, input logic [31:0] d);
		host_go(a, r, h, d);
		host_wait(300);
		check("host ready", 32'h1, {31'h0, got});
		host_end();
		check("bus enable", {31'h0, r}, {31'h0, oe_at});
	endtask : host_x

	initial begin
		{cs_n, as_n, pol} = 3'b111;
		{ds1, ds2, rnw, hws, cpu_req, cpu_we, stall} = 7'h00;
		{acc, hd_in, cpu_addr, cpu_wdata} = '0;
		func    = FUNC_HOST32;
		i_rst_n = 1'b0;
		repeat (20) @(posedge i_core_clk);
		#DRV;
		i_rst_n = 1'b1;
		repeat (3) @(posedge i_core_clk);
		#DRV;
		check("ready reset", 32'h1, {31'h0, ready_n});
		for (int i = 0; i < 4; i++) begin
			cpu_rw(1'b0, REG_OFFS[i], 32'h0);
			check("reg reset", RESET_WORD, rd);
		end
		cpu_rw(1'b1, OFF_CTRL, 32'hffff_ff5a);
		cpu_rw(1'b0, OFF_CTRL, 32'h0);
		check("ctrl cpu", 32'hffff_ff5a & CTRL_RW_MASK, rd);
		host_x(SEL_CTRL, 1'b1, 1'b0, 32'h0);
		check("ctrl host", 32'h0000_005a, rd);
		host_x(SEL_CTRL, 1'b0, 1'b0, 32'h0000_0032);
		cpu_rw(1'b0, OFF_CTRL, 32'h0);
		check("ctrl host write", 32'h0000_0032, rd);
		cpu_rw(1'b1, OFF_AW, 32'h0000_0100);
		cpu_rw(1'b1, OFF_AR, 32'h0000_0200);
		cpu_rw(1'b0, OFF_AW, 32'h0);
		check("write copy", 32'h0000_0100, rd);
		cpu_rw(1'b0, OFF_AR, 32'h0);
		check("read copy", 32'h0000_0200, rd);
		cpu_rw(1'b1, 32'h0188_000c, 32'hffff_ffff);
		cpu_rw(1'b0, 32'h0188_000c, 32'h0);
		check("reserved", 32'h0, rd);
		cpu_rw(1'b0, 32'h018a_0004, 32'h0);
		check("reserved", 32'h0, rd);
		// Selects latched at the address strobe win over the pins seen at the strobe fall.
		acc   = SEL_ADDR;
		rnw   = 1'b0;
		hd_in = 32'h0000_00a0;
		@(posedge i_core_clk);
		#DRV;
		as_n = 1'b0;
		repeat (2) @(posedge i_core_clk);
		#DRV;
		as_n = 1'b1;
		host_x(SEL_CTRL, 1'b0, 1'b0, 32'h0000_00a0);
		for (int i = 0; i < 3; i++) begin
			cpu_rw(1'b0, REG_OFFS[i == 2 ? 0 : i + 1], 32'h0);
			check("pointer copies", i == 2 ? 32'h32 : 32'ha0, rd);
		end
		stall = 1'b1;
		f0    = fetches;
		host_go(SEL_DATA_FIX, 1'b1, 1'b0, 32'h0);
		host_wait(20);
		check("ready while fetching", 32'h0, {31'h0, got});
		#DRV;
		stall = 1'b0;
		host_wait(300);
		host_end();
		check("window read", pat(40), rd);
		check("fetches", 32'h1, 32'(fetches - f0));
		func = FUNC_HOST16;
		repeat (3) @(posedge i_core_clk);
		#DRV;
		f0 = fetches;
		host_x(SEL_DATA_FIX, 1'b1, 1'b0, 32'h0);
		check("first half", pat(40) & 32'h0000_ffff, {16'h0, rd[15:0]});
		host_x(SEL_DATA_FIX, 1'b1, 1'b1, 32'h0);
		check("second half", pat(40) >> 16, {16'h0, rd[15:0]});
		check("half fetches", 32'h1, 32'(fetches - f0));
		host_x(SEL_DATA_FIX, 1'b0, 1'b0, 32'h0000_1111);
		host_x(SEL_DATA_FIX, 1'b0, 1'b1, 32'h0000_2222);
		repeat (20) @(posedge i_core_clk);
		check("half write", 32'h2222_1111, eng.mem_reg[40]);
		// A PCI pin function and a deselected chip must both stay silent.
		for (int k = 0; k < 2; k++) begin
			func = k == 0 ? FUNC_PCI : FUNC_HOST32;
			acc  = SEL_CTRL;
			rnw  = 1'b1;
			repeat (3) @(posedge i_core_clk);
			#DRV;
			cs_n = k == 0 ? 1'b0 : 1'b1;
			ds1  = 1'b1;
			host_wait(10);
			check("no answer", 32'h0, {31'h0, got});
			check("no drive", 32'h0, {31'h0, oe});
			#DRV;
			cs_n = 1'b1;
			ds1  = 1'b0;
		end
		repeat (3) @(posedge i_core_clk);
		#DRV;
		host_x(SEL_ADDR, 1'b0, 1'b0, 32'h0);
		stall = 1'b1;
		n     = 0;
		got   = 1'b1;
		while (got && n < 24) begin
			host_go(SEL_DATA_INC, 1'b0, 1'b0, 32'hd000_0000 | n);
			host_wait(10);
			if (got) begin
				host_end();
				n++;
			end
		end
		check("accepted", 32'h1, {31'h0, n >= WBUF_DEPTH && n <= WBUF_DEPTH + 2});
		check("ready held full", 32'h1, {31'h0, ready_n});
		#DRV;
		stall = 1'b0;
		host_wait(300);
		check("ready after drain", 32'h1, {31'h0, got});
		host_end();
		n++;
		repeat (150) @(posedge i_core_clk);
		for (int i = 0; i < n; i++) begin
			check("buffered word", 32'hd000_0000 | i, eng.mem_reg[i]);
		end
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
